/* File: verilog/swd_watchdog.sv */
// staged watchdog timer with an axi4-lite register port
// assumes one clock; the bus master keeps axi4-lite handshake order
`timescale 1ns/1ps
`include "swd_defines.svh"
module swd_watchdog #(
   parameter int unsigned TICK_CYCLES = `SWD_TICK_CYCLES,
   parameter bit EVENT_SUPPORT = 1'b1,
   parameter int unsigned ADDR_W = 8
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output swd_pkg::swd_evt_out_s evt_out,
   output logic board_reset_req,
   output logic irq
);
   import swd_pkg::*;

   if (ADDR_W < 8) begin : g_bad
      $error("swd_watchdog: ADDR_W below 8");
   end

   // largest event time this build accepts
   localparam logic [7:0] MAX_EVT = EVENT_SUPPORT ? `SWD_MAX_TICKS : 8'h00;

   swd_cfg_s cfg; // programmed settings
   swd_state_e state; // timer state
   logic [7:0] cnt; // elapsed ticks
   logic evt_done; // event already raised this round
   logic tick; // one-second tick
   logic [ADDR_W-1:0] aw_addr; // held write address
   logic [31:0] w_data; // held write data
   logic [3:0] w_strb; // held byte enables
   logic do_write; // address and data both held
   logic [31:0] wr_val; // write data merged over old value
   logic [32:0] wr_old; // hit flag and old value at write address
   logic [32:0] rd_word; // hit flag and value at read address
   logic [31:0] lane; // byte-enable mask
   logic wr_err; // write refused
   logic start_cmd, trig_cmd, stop_cmd; // command pulses
   logic trig_ok; // trigger accepted
   logic we_delay, we_rst, we_evt_t, we_evt_ty, we_mask; // register writes
   logic [`SWD_INT_W-1:0] int_clr; // write-one-to-clear bits
   logic [`SWD_INT_W-1:0] int_set; // events into sticky bits
   logic [`SWD_INT_W-1:0] int_st; // sticky status
   logic [`SWD_INT_W-1:0] int_mask; // interrupt mask
   logic armed; // delay time has elapsed
   logic evt_hit, rst_hit; // count reached event or reset time

   // register view for one address: hit flag and read value
   function automatic logic [32:0] reg_view(input logic [7:0] a);
      unique case (a)
         `SWD_OFF_CMD: reg_view = {1'b1, 32'h0};
         `SWD_OFF_DELAY: reg_view = {1'b1, 24'h0, cfg.delay_t};
         `SWD_OFF_RST: reg_view = {1'b1, 24'h0, cfg.reset_t};
         `SWD_OFF_EVT_TIME: reg_view = {1'b1, 24'h0, cfg.event_t};
         `SWD_OFF_EVT_TYPE: reg_view = {1'b1, 30'h0, cfg.etype};
         `SWD_OFF_STATUS: reg_view = {1'b1, 16'h0, cnt, 5'h0,
            state == SWD_EXPIRED, armed, state == SWD_RUN};
         `SWD_OFF_INT_ST: reg_view = {1'b1, 29'h0, int_st};
         `SWD_OFF_INT_MASK: reg_view = {1'b1, 29'h0, int_mask};
         // capabilities: max event, max delay/reset, event support
         `SWD_OFF_CAPS: reg_view = {1'b1, 8'h0, MAX_EVT, `SWD_MAX_TICKS,
            7'h0, EVENT_SUPPORT};
         default: reg_view = {1'b0, 32'h0};
      endcase
   endfunction

   // write address channel: take once, reopen after the response
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_axi_awready <= 1'b1;
         aw_addr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         aw_addr <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_awready <= 1'b1;
      end
   end

   // write data channel, independent of the address
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_axi_wready <= 1'b1;
         w_data <= 32'h0;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_wready <= 1'b1;
      end
   end

   assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign lane = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
   // a process, so the view follows the settings the function reads
   always_comb begin
      wr_old = reg_view(aw_addr[7:0]);
   end
   assign wr_val = (w_data & lane) | (wr_old[31:0] & ~lane);

   // write decode: enables, range checks, command pulses
   always_comb begin
      wr_err = 1'b0;
      start_cmd = 1'b0;
      trig_cmd = 1'b0;
      stop_cmd = 1'b0;
      we_delay = 1'b0;
      we_rst = 1'b0;
      we_evt_t = 1'b0;
      we_evt_ty = 1'b0;
      we_mask = 1'b0;
      int_clr = '0;
      if (do_write) begin
         unique case (aw_addr[7:0])
            // command bits act once, read back as zero
            `SWD_OFF_CMD: begin
               start_cmd = wr_val[`SWD_CMD_START];
               trig_cmd = wr_val[`SWD_CMD_TRIGGER];
               stop_cmd = wr_val[`SWD_CMD_STOP];
            end
            `SWD_OFF_DELAY: begin
               wr_err = wr_val > 32'(`SWD_MAX_TICKS);
               we_delay = !wr_err;
            end
            `SWD_OFF_RST: begin
               wr_err = wr_val > 32'(`SWD_MAX_TICKS);
               we_rst = !wr_err;
            end
            `SWD_OFF_EVT_TIME: begin
               wr_err = wr_val > 32'(MAX_EVT);
               we_evt_t = !wr_err;
            end
            // only the none type is legal without event support
            `SWD_OFF_EVT_TYPE: begin
               wr_err = (wr_val > 32'h3) || (!EVENT_SUPPORT && wr_val != 32'h0);
               we_evt_ty = !wr_err;
            end
            `SWD_OFF_INT_ST: int_clr = wr_val[`SWD_INT_W-1:0];
            `SWD_OFF_INT_MASK: we_mask = 1'b1;
            // status and capabilities are read only
            `SWD_OFF_STATUS, `SWD_OFF_CAPS: wr_err = 1'b0;
            default: wr_err = 1'b1;
         endcase
      end
   end

   // write response, slave error for a refused or unmapped write
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SWD_RESP_OK;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_err ? `SWD_RESP_SLVERR : `SWD_RESP_OK;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // read channel: answer one cycle after the address is taken
   // a process, so read data tracks count and status as they move
   always_comb begin
      rd_word = reg_view(s_axi_araddr[7:0]);
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `SWD_RESP_OK;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word[31:0];
         s_axi_rresp <= rd_word[32] ? `SWD_RESP_OK : `SWD_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // settings, each kept unless an accepted write changes it
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cfg.delay_t <= `SWD_RST_TIME;
         cfg.reset_t <= `SWD_RST_TIME;
         cfg.event_t <= `SWD_RST_TIME;
         cfg.etype <= SWD_EVT_NONE;
      end else begin
         if (we_delay) cfg.delay_t <= wr_val[7:0];
         if (we_rst) cfg.reset_t <= wr_val[7:0];
         if (we_evt_t) cfg.event_t <= wr_val[7:0];
         if (we_evt_ty) cfg.etype <= swd_evt_e'(wr_val[1:0]);
      end
   end

   // timer conditions
   assign armed = cnt >= cfg.delay_t;
   assign trig_ok = trig_cmd && !stop_cmd && !start_cmd
      && state == SWD_RUN && armed;
   assign rst_hit = state == SWD_RUN && cnt == cfg.reset_t;
   assign evt_hit = state == SWD_RUN && cfg.etype != SWD_EVT_NONE
      && cnt == cfg.event_t && !evt_done;

   swd_prescaler #(
      .CYCLES(TICK_CYCLES)
   ) u_prescaler (
      .clk(clk),
      .reset(reset),
      .clear(start_cmd || trig_ok),
      .run(state == SWD_RUN),
      .tick(tick)
   );

   // timer state and tick count
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state <= SWD_IDLE;
         cnt <= 8'h00;
         evt_done <= 1'b0;
      end else if (stop_cmd) begin
         state <= SWD_IDLE;
      end else if (start_cmd || trig_ok) begin
         state <= SWD_RUN;
         cnt <= 8'h00;
         evt_done <= 1'b0;
      end else begin
         unique case (state)
            SWD_IDLE: cnt <= cnt;
            // reset ends the round and halts the count
            SWD_RUN: begin
               if (rst_hit) begin
                  state <= SWD_EXPIRED;
               end else if (tick && cnt != 8'hff) begin
                  cnt <= cnt + 8'h01;
               end
               if (evt_hit) evt_done <= 1'b1;
            end
            SWD_EXPIRED: cnt <= cnt;
            default: state <= SWD_IDLE;
         endcase
      end
   end

   // event and board reset lines, held until a stop, a start or an accepted trigger
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         evt_out <= '0;
         board_reset_req <= 1'b0;
      end else if (stop_cmd || start_cmd || trig_ok) begin
         evt_out <= '0;
         board_reset_req <= 1'b0;
      end else begin
         if (rst_hit) board_reset_req <= 1'b1;
         if (evt_hit) begin
            evt_out.irq <= evt_out.irq || cfg.etype == SWD_EVT_IRQ;
            evt_out.sci <= evt_out.sci || cfg.etype == SWD_EVT_SCI;
            evt_out.pwrbtn <= evt_out.pwrbtn || cfg.etype == SWD_EVT_PWR;
         end
      end
   end

   assign int_set = {do_write && wr_err, rst_hit && !board_reset_req, evt_hit};

   swd_irq_bank #(
      .W(`SWD_INT_W)
   ) u_irq (
      .clk(clk),
      .reset(reset),
      .set(int_set),
      .clr(int_clr),
      .mask_we(we_mask),
      .mask_wdata(wr_val[`SWD_INT_W-1:0]),
      .status(int_st),
      .mask(int_mask),
      .irq(irq)
   );
endmodule // swd_watchdog

/* File: verilog/swd_defines.svh */
// constants of the staged watchdog: offsets, fields, resets, timing
// assumes a 100 mhz clock and a 32-bit register bus
`ifndef SWD_DEFINES_SVH
`define SWD_DEFINES_SVH
// clock rate and the time unit of every watchdog time setting
`define SWD_CLK_KHZ 100000
`define SWD_TICK_MS 1000
`define SWD_TICK_CYCLES (`SWD_TICK_MS * `SWD_CLK_KHZ)
// largest delay and reset time, in ticks
`define SWD_MAX_TICKS 8'hff
// register byte offsets
`define SWD_OFF_CMD 8'h00
`define SWD_OFF_DELAY 8'h04
`define SWD_OFF_RST 8'h08
`define SWD_OFF_EVT_TIME 8'h0c
`define SWD_OFF_EVT_TYPE 8'h10
`define SWD_OFF_STATUS 8'h14
`define SWD_OFF_INT_ST 8'h18
`define SWD_OFF_INT_MASK 8'h1c
`define SWD_OFF_CAPS 8'h20
// command bits
`define SWD_CMD_START 0
`define SWD_CMD_TRIGGER 1
`define SWD_CMD_STOP 2
// interrupt status bits
`define SWD_INT_EVT 0
`define SWD_INT_RST 1
`define SWD_INT_ERR 2
`define SWD_INT_W 3
// reset values
`define SWD_RST_TIME 8'h00
`define SWD_RST_MASK 3'h0
// bus responses
`define SWD_RESP_OK 2'b00
`define SWD_RESP_SLVERR 2'b10
`endif

/* File: verilog/swd_pkg.sv */
// types of the staged watchdog
// assumes nothing beyond the constants header
package swd_pkg;
   // event chosen on reaching the event time
   typedef enum logic [1:0] {
      SWD_EVT_NONE = 2'b00,
      SWD_EVT_IRQ = 2'b01,
      SWD_EVT_SCI = 2'b10,
      SWD_EVT_PWR = 2'b11
   } swd_evt_e;
   // timer states
   typedef enum logic [1:0] {
      SWD_IDLE = 2'b00,
      SWD_RUN = 2'b01,
      SWD_EXPIRED = 2'b10
   } swd_state_e;
   // programmed settings: delay, reset and event times in ticks, and the event type
   typedef struct packed {
      logic [7:0] delay_t;
      logic [7:0] reset_t;
      logic [7:0] event_t;
      swd_evt_e etype;
   } swd_cfg_s;
   // event lines towards the host
   typedef struct packed {
      logic irq;
      logic sci;
      logic pwrbtn;
   } swd_evt_out_s;
endpackage

/* File: verilog/swd_prescaler.sv */
// one-second tick generator for the watchdog counter
// assumes clear and run come from logic on the same clock
`timescale 1ns/1ps
module swd_prescaler #(
   parameter int unsigned CYCLES = 100
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic clear,
   input wire logic run,
   output logic tick
);
   localparam int unsigned W = $clog2(CYCLES);
   localparam logic [W-1:0] LAST = W'(CYCLES - 1);
   // refuse a period the counter cannot serve
   if (CYCLES < 2) begin : g_bad
      $error("swd_prescaler: CYCLES below 2");
   end
   logic [W-1:0] count; // cycles within the current tick
   // count cycles while running, restart on clear
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         count <= '0;
         tick <= 1'b0;
      end else if (clear || !run) begin
         count <= '0;
         tick <= 1'b0;
      end else if (count == LAST) begin
         count <= '0;
         tick <= 1'b1;
      end else begin
         count <= count + W'(1);
         tick <= 1'b0;
      end
   end
endmodule // swd_prescaler

/* File: verilog/swd_irq_bank.sv */
// sticky status bits with a mask, driving one level interrupt
// assumes set and clear pulses from logic on the same clock
`timescale 1ns/1ps
`include "swd_defines.svh"
module swd_irq_bank #(
   parameter int unsigned W = 3
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [W-1:0] set,
   input wire logic [W-1:0] clr,
   input wire logic mask_we,
   input wire logic [W-1:0] mask_wdata,
   output logic [W-1:0] status,
   output logic [W-1:0] mask,
   output logic irq
);
   if (W < 1) begin : g_bad
      $error("swd_irq_bank: W below 1");
   end
   // sticky bits, write one to clear, a new event wins over the clear
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         status <= '0;
      end else begin
         status <= (status & ~clr) | set;
      end
   end
   // mask register
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         mask <= W'(`SWD_RST_MASK);
      end else if (mask_we) begin
         mask <= mask_wdata;
      end
   end
   // registered interrupt level
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status & mask);
      end
   end
endmodule // swd_irq_bank

/* File: verification/swd_watchdog_chk.sv */
// port assertions for the staged watchdog, bound into swd_watchdog
// assumes a master that keeps the axi4-lite handshake
`timescale 1ns/1ps
`include "swd_defines.svh"
module swd_watchdog_chk #(
   parameter int unsigned ADDR_W = 8
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire swd_pkg::swd_evt_out_s evt_out,
   input wire logic board_reset_req,
   input wire logic irq
);
   import swd_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // address and data of a write taken at one edge
   logic wr_both;
   assign wr_both = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   // the response rises at the second edge after both halves are taken
   chk_wr_answer: assert property (wr_both |-> ##2 s_axi_bvalid)
      else $error("write response missing");
   chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data missing");
   chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   chk_ready_low: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("new write taken during response");
   chk_range_error: assert property (wr_both && s_axi_awaddr[7:0] == `SWD_OFF_DELAY &&
      s_axi_wstrb == 4'hf && s_axi_wdata[31:8] != 24'h0 |-> ##2 s_axi_bresp == `SWD_RESP_SLVERR)
      else $error("out of range delay accepted");
   chk_one_event: assert property ($onehot0(evt_out))
      else $error("more than one event line");
   chk_rst_stands: assert property (board_reset_req && s_axi_awready |=> board_reset_req)
      else $error("board reset request dropped");
   chk_evt_stands: assert property (evt_out != 3'h0 && s_axi_awready |=> evt_out == $past(evt_out))
      else $error("event line changed without command");
   chk_stop_clears: assert property (wr_both && s_axi_awaddr[7:0] == `SWD_OFF_CMD &&
      s_axi_wstrb[0] && s_axi_wdata[`SWD_CMD_STOP] |=> ##[1:2] !board_reset_req && evt_out == 3'h0)
      else $error("stop left outputs raised");
   chk_reset_quiet: assert property ($fell(reset) |-> !board_reset_req && evt_out == 3'h0 && !irq)
      else $error("outputs raised out of reset");
   // main scenarios reached
   cover property ($rose(board_reset_req));
   cover property ($rose(evt_out.irq));
   cover property ($rose(irq));
   cover property (s_axi_bvalid && s_axi_bresp == `SWD_RESP_SLVERR);
endmodule // swd_watchdog_chk
bind swd_watchdog swd_watchdog_chk #(.ADDR_W(ADDR_W)) u_chk (.clk(clk), .reset(reset),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .evt_out(evt_out), .board_reset_req(board_reset_req), .irq(irq));

/* File: verification/testbench.sv */
// self-checking bench for the staged watchdog over axi4-lite
// assumes a short tick so that whole rounds fit in a brief run
`timescale 1ns/1ps
`include "swd_defines.svh"
module testbench;
   import swd_pkg::*;
   localparam int TICK = 20; // cycles per watchdog tick
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, board_reset_req, irq;
   logic [1:0] bresp, rresp;
   swd_evt_out_s evt_out;
   int error_cnt = 0;
   int num_checks = 0;
   logic [31:0] d; // last read word
   logic [1:0] r; // last read response
   swd_watchdog #(.TICK_CYCLES(TICK), .EVENT_SUPPORT(1'b1), .ADDR_W(8)) dut (
      .clk(clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .evt_out(evt_out), .board_reset_req(board_reset_req), .irq(irq));
   // free-running clock
   always #5 clk = ~clk;
   // compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // one write, address and data offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid && n < 100);
      check({31'h0, bvalid}, 32'h1);
      check({30'h0, bresp}, {30'h0, er});
      bready <= 1'b0;
      @(posedge clk);
   endtask
   // one read, result left in d and r
   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (arready) arvalid <= 1'b0;
      end while (!rvalid && n < 100);
      check({31'h0, rvalid}, 32'h1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge clk);
   endtask
   // program the four settings
   task automatic cfg(input logic [7:0] dl, input logic [7:0] rt, input logic [7:0] et,
                      input logic [1:0] ty);
      wr(`SWD_OFF_DELAY, {24'h0, dl}, `SWD_RESP_OK);
      wr(`SWD_OFF_RST, {24'h0, rt}, `SWD_RESP_OK);
      wr(`SWD_OFF_EVT_TIME, {24'h0, et}, `SWD_RESP_OK);
      wr(`SWD_OFF_EVT_TYPE, {30'h0, ty}, `SWD_RESP_OK);
   endtask
   // reset values, limits, refused settings, unmapped places
   task automatic s_regs();
      rd(`SWD_OFF_DELAY);
      check(d, 32'h0);
      rd(`SWD_OFF_CAPS);
      check(d, 32'h00ffff01);
      wr(`SWD_OFF_DELAY, 32'hff, `SWD_RESP_OK);
      wr(`SWD_OFF_DELAY, 32'h100, `SWD_RESP_SLVERR);
      rd(`SWD_OFF_DELAY);
      check(d, 32'hff);
      wr(`SWD_OFF_EVT_TYPE, 32'h4, `SWD_RESP_SLVERR);
      rd(`SWD_OFF_INT_ST);
      check(d, 32'h4);
      wr(`SWD_OFF_INT_ST, 32'h4, `SWD_RESP_OK);
      wr(8'h24, 32'h1, `SWD_RESP_SLVERR);
      rd(8'h24);
      check({30'h0, r}, {30'h0, `SWD_RESP_SLVERR});
      check(d, 32'h0);
   endtask
   // every event type, then stop before the reset time
   task automatic s_events();
      logic [2:0] exp;
      wr(`SWD_OFF_INT_MASK, 32'h1, `SWD_RESP_OK);
      for (int t = 0; t < 4; t++) begin
         exp = (t == 1) ? 3'b100 : (t == 2) ? 3'b010 : (t == 3) ? 3'b001 : 3'b000;
         cfg(8'h0, 8'h6, 8'h2, t[1:0]);
         wr(`SWD_OFF_CMD, 32'h1, `SWD_RESP_OK);
         cyc(2 * TICK - 4);
         check({29'h0, evt_out}, 32'h0);
         cyc(8);
         check({29'h0, evt_out}, {29'h0, exp});
         check({31'h0, irq}, {31'h0, t != 0});
         wr(`SWD_OFF_CMD, 32'h4, `SWD_RESP_OK);
         cyc(6 * TICK);
         check({30'h0, board_reset_req, |evt_out}, 32'h0);
         wr(`SWD_OFF_INT_ST, 32'h7, `SWD_RESP_OK);
      end
   endtask
   // nothing counts before start; reset request at the reset time
   task automatic s_reset();
      cfg(8'h0, 8'h3, 8'h0, SWD_EVT_NONE);
      cyc(4 * TICK);
      check({31'h0, board_reset_req}, 32'h0);
      wr(`SWD_OFF_CMD, 32'h1, `SWD_RESP_OK);
      cyc(3 * TICK - 4);
      check({31'h0, board_reset_req}, 32'h0);
      cyc(8);
      check({31'h0, board_reset_req}, 32'h1);
      // count frozen at 3, expired, delay elapsed, not running
      rd(`SWD_OFF_STATUS);
      check(d, 32'h00000306);
      wr(`SWD_OFF_INT_MASK, 32'h2, `SWD_RESP_OK);
      check({31'h0, irq}, 32'h1);
      wr(`SWD_OFF_INT_MASK, 32'h0, `SWD_RESP_OK);
      check({31'h0, irq}, 32'h0);
      wr(`SWD_OFF_INT_ST, 32'h7, `SWD_RESP_OK);
      wr(`SWD_OFF_CMD, 32'h4, `SWD_RESP_OK);
   endtask
   // early trigger ignored, late trigger restarts the count
   task automatic s_trigger();
      cfg(8'h2, 8'h4, 8'h0, SWD_EVT_NONE);
      wr(`SWD_OFF_CMD, 32'h1, `SWD_RESP_OK);
      cyc(TICK);
      wr(`SWD_OFF_CMD, 32'h2, `SWD_RESP_OK);
      cyc(3 * TICK - 2);
      check({31'h0, board_reset_req}, 32'h1);
      wr(`SWD_OFF_CMD, 32'h4, `SWD_RESP_OK);
      wr(`SWD_OFF_CMD, 32'h1, `SWD_RESP_OK);
      cyc(3 * TICK);
      wr(`SWD_OFF_CMD, 32'h2, `SWD_RESP_OK);
      cyc(2 * TICK);
      check({31'h0, board_reset_req}, 32'h0);
      // an uncleared prescaler would raise the request four cycles early
      cyc(2 * TICK - 2);
      check({31'h0, board_reset_req}, 32'h0);
      cyc(8);
      check({31'h0, board_reset_req}, 32'h1);
      wr(`SWD_OFF_CMD, 32'h4, `SWD_RESP_OK);
   endtask
   // main sequence
   initial begin
      cyc(8);
      reset <= 1'b0;
      cyc(2);
      s_regs();
      s_events();
      s_reset();
      s_trigger();
      conclude();
   end
   // hang guard, far beyond the expected run
   initial begin
      cyc(40000);
      error_cnt++;
      conclude();
   end
endmodule // testbench
